/* File: rtl/sfdl_params.svh */
/*
 * Constants of the supply fault deglitch logger: register offsets, field
 * positions, reset values, deglitch counts and fault record layout.
 * Assumes inclusion by bare name from the block's package and modules.
 */
`ifndef SFDL_PARAMS_SVH
`define SFDL_PARAMS_SVH

`define SFDL_NUM_CH 12
// main page offsets
`define SFDL_THR_FIRST 8'h23
`define SFDL_THR_LAST 8'h46
`define SFDL_LOG_CTL 8'h47
`define SFDL_UV_EN_LO 8'h48
`define SFDL_UV_EN_HI 8'h49
`define SFDL_OV_EN_LO 8'h4A
`define SFDL_EW_EN_LO 8'h4B
`define SFDL_EW_EN_HI 8'h4C
`define SFDL_DGL_CFG 8'h4F
`define SFDL_UNLOCK 8'h5D
// extended page offsets
`define SFDL_FLAGS_LO 8'h18
`define SFDL_FLAGS_HI 8'h19
// field positions
`define SFDL_DGL_MSB 7
`define SFDL_DGL_LSB 6
`define SFDL_UNLOCK_BIT 1
// threshold slot within a channel's group of three
`define SFDL_THR_EW 6'h00
`define SFDL_THR_OV 6'h01
`define SFDL_THR_UV 6'h02
`define SFDL_THR_DEPTH 36
// fault record layout
`define SFDL_REC_HEAD 4'h0
`define SFDL_REC_FLAG_LO 4'h1
`define SFDL_REC_FLAG_HI 4'h2
`define SFDL_REC_ADC0 4'h3
`define SFDL_REC_LAST 4'hE
`define SFDL_REC_DEPTH 15
// log control encodings
`define SFDL_LOG_BOTH 2'h0
`define SFDL_LOG_FLAGS 2'h1
`define SFDL_LOG_ADC 2'h2
`define SFDL_LOG_OFF 2'h3
// reset values
`define SFDL_RST_LOG_CTL 2'h0
`define SFDL_RST_DGL 2'h0
`define SFDL_RST_EN 12'h000
// acquisitions needed per deglitch setting
`define SFDL_DGL_N0 4'h1
`define SFDL_DGL_N1 4'h2
`define SFDL_DGL_N2 4'h4
`define SFDL_DGL_N3 4'h8

`endif

/* File: rtl/sfdl_pkg.sv */
/*
 * Types of the supply fault deglitch logger.
 * Assumes sfdl_params.svh is on the include path.
 */
package sfdl_pkg;
  `include "sfdl_params.svh"

  typedef enum logic [2:0] {
    SFDL_IDLE,
    SFDL_GET_EW,
    SFDL_GET_OV,
    SFDL_EVAL,
    SFDL_LOG
  } sfdl_state_t;

  typedef struct packed {
    sfdl_state_t state;
    logic [3:0] chan;
    logic [7:0] cur;
    logic [7:0] thr_ew;
    logic [7:0] thr_ov;
    logic [3:0] cnt;
    logic [11:0] flags;
    logic [11:0] fault_pin;
    logic [11:0] en_uv;
    logic [11:0] en_ov;
    logic [11:0] en_ew;
    logic [1:0] log_ctl;
    logic [1:0] dgl;
    logic lock;
    logic shutdown;
    logic [3:0] log_idx;
    logic rd_q;
    logic [7:0] rd_addr;
    logic rd_ext;
    logic rd_nv;
    logic [7:0] rdata;
    logic rvalid;
    logic [11:0] supply_en;
  } sfdl_regs_t;
endpackage

/* File: rtl/sfdl_mem.sv */
/*
 * Small byte memory: one write port, two read ports with registered data.
 * Assumes a single clock and synchronous active-low reset clearing contents.
 */
`timescale 1ns/1ps
module sfdl_mem #(
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic i_clk,              // clock
  input wire logic i_reset_n,          // sync reset, active low
  input wire logic i_wr_en,            // write strobe
  input wire logic [AW-1:0] i_wr_addr, // write address
  input wire logic [7:0] i_wr_data,    // write data
  input wire logic [AW-1:0] i_rd_a_addr, // read port a address
  output logic [7:0] o_rd_a_data,      // read port a data, registered
  input wire logic [AW-1:0] i_rd_b_addr, // read port b address
  output logic [7:0] o_rd_b_data       // read port b data, registered
);
  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
    logic [7:0] rd_a;
    logic [7:0] rd_b;
  } sfdl_mem_t;

  sfdl_mem_t st;
  sfdl_mem_t next_st;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st = st;
    if (i_wr_en && (int'(i_wr_addr) < DEPTH)) begin
      next_st.mem[i_wr_addr] = i_wr_data;
    end
    // out-of-range addresses read zero
    next_st.rd_a = (int'(i_rd_a_addr) < DEPTH) ? st.mem[i_rd_a_addr] : 8'h00;
    next_st.rd_b = (int'(i_rd_b_addr) < DEPTH) ? st.mem[i_rd_b_addr] : 8'h00;
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      next_st_reset : st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_rd_a_data = st.rd_a;
  assign o_rd_b_data = st.rd_b;
endmodule

/* File: rtl/sfdl_top.sv */
/*
 * Supply fault deglitch logger: threshold checks on each conversion,
 * deglitch by holding the channel, W1C fault flags, critical shutdown and
 * fault record writer with lock.
 * Assumes conversion results belong to the channel on o_chan_sel and that a
 * new conversion never completes within 4 cycles of the previous one.
 */
//
// Summary of operation
// - evaluate an input only after conversion completes
// - violating input holds the channel for reconversion
// - fault needs consecutive violations per deglitch field
// - flags readable anytime at extended 18h/19h
// - write one clears flag, zero keeps it
// - flag sets only with matching critical enable
// - fault pins ignore critical enables
// - critical fault drops supplies, starts record write
// - critical only when enabled in 48h-4Ch
// - record goes to log locations 00h-0Eh
// - written log locks memory against new logs
// - writing one to 5Dh bit1 unlocks log
// - log control chooses flags, ADC, both, none
// - flags go to log locations 01h and 02h
// - logged ADC results are eight bits
// - flag bit layout: inputs 1-8, 9-12
// - undervoltage enables at 48h and 49h low
// - overvoltage enables at 49h high and 4Ah
// - early warning enables at 4Bh, 4Ch low
// - compare top eight result bits to thresholds
//
`timescale 1ns/1ps
module sfdl_top #(
  parameter int ADC_W = 10,
  parameter logic [11:0] EW_ABOVE = 12'h000
) (
  input wire logic i_clk,                 // clock, 40 MHz
  input wire logic i_reset_n,             // sync reset, active low
  input wire logic i_conv_done,           // conversion complete pulse
  input wire logic [ADC_W-1:0] i_conv_data, // conversion result
  output logic [3:0] o_chan_sel,          // channel to convert
  input wire logic i_reg_wr,              // register write strobe
  input wire logic i_reg_rd,              // register read strobe
  input wire logic [7:0] i_reg_addr,      // register offset
  input wire logic [7:0] i_reg_wdata,     // register write data
  input wire logic i_reg_ext,             // extended page select
  input wire logic i_reg_nv,              // log memory page select
  output logic [7:0] o_reg_rdata,         // read data
  output logic o_reg_rvalid,              // read data valid pulse
  input wire logic [11:0] i_supply_req,   // enables wanted by sequencer
  output logic [11:0] o_supply_en,        // supply enable outputs
  output logic [11:0] o_fault,            // unmasked per-input fault
  output logic o_shutdown,                // critical fault latched
  output logic o_log_locked               // log memory locked
);
  import sfdl_pkg::*;

  sfdl_pkg::sfdl_regs_t st;
  sfdl_pkg::sfdl_regs_t next_st;

  logic [7:0] thr_a;
  logic [7:0] thr_b;
  logic [7:0] adc_a;
  logic [7:0] log_b;
  logic [5:0] thr_rd_addr;
  logic [5:0] thr_wr_addr;
  logic thr_wr;
  logic [3:0] adc_rd_addr;
  logic adc_wr;
  logic log_wr;
  logic [7:0] log_wdata;
  logic [7:0] cur8;

  function automatic logic [3:0] dgl_need(input logic [1:0] f);
    case (f)
      2'h0: dgl_need = `SFDL_DGL_N0;
      2'h1: dgl_need = `SFDL_DGL_N1;
      2'h2: dgl_need = `SFDL_DGL_N2;
      default: dgl_need = `SFDL_DGL_N3;
    endcase
  endfunction

  function automatic logic [5:0] thr_slot(input logic [3:0] ch, input logic [5:0] k);
    thr_slot = 6'(ch * 3) + k;
  endfunction

  function automatic logic main_wr(input logic [7:0] off);
    main_wr = i_reg_wr && !i_reg_ext && !i_reg_nv && (i_reg_addr == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // memories: thresholds, last results, fault record

  assign cur8 = i_conv_data[ADC_W-1 -: 8];
  assign thr_wr = i_reg_wr && !i_reg_ext && !i_reg_nv &&
                  (i_reg_addr >= `SFDL_THR_FIRST) && (i_reg_addr <= `SFDL_THR_LAST);
  assign thr_wr_addr = 6'(i_reg_addr - `SFDL_THR_FIRST);
  assign adc_wr = (st.state == SFDL_IDLE) && i_conv_done;
  assign adc_rd_addr = st.log_idx - 4'h2;

  always_comb begin
    case (st.state)
      SFDL_IDLE: thr_rd_addr = thr_slot(st.chan, `SFDL_THR_EW);
      SFDL_GET_EW: thr_rd_addr = thr_slot(st.chan, `SFDL_THR_OV);
      default: thr_rd_addr = thr_slot(st.chan, `SFDL_THR_UV);
    endcase
  end

  sfdl_mem #(.DEPTH(`SFDL_THR_DEPTH), .AW(6)) u_thr (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_wr_en(thr_wr),
    .i_wr_addr(thr_wr_addr),
    .i_wr_data(i_reg_wdata),
    .i_rd_a_addr(thr_rd_addr),
    .o_rd_a_data(thr_a),
    .i_rd_b_addr(thr_wr_addr),
    .o_rd_b_data(thr_b)
  );

  sfdl_mem #(.DEPTH(`SFDL_NUM_CH), .AW(4)) u_adc (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_wr_en(adc_wr),
    .i_wr_addr(st.chan),
    .i_wr_data(cur8),
    .i_rd_a_addr(adc_rd_addr),
    .o_rd_a_data(adc_a),
    .i_rd_b_addr(4'h0),
    .o_rd_b_data()
  );

  sfdl_mem #(.DEPTH(`SFDL_REC_DEPTH), .AW(4)) u_log (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_wr_en(log_wr),
    .i_wr_addr(st.log_idx),
    .i_wr_data(log_wdata),
    .i_rd_a_addr(4'h0),
    .o_rd_a_data(),
    .i_rd_b_addr(i_reg_addr[3:0]),
    .o_rd_b_data(log_b)
  );

  ////////////////////////////////////////////////////////////////////////////
  // record writer data

  always_comb begin
    log_wr = 1'b0;
    log_wdata = 8'h00;
    if (st.state == SFDL_LOG) begin
      if (st.log_idx == `SFDL_REC_HEAD) begin
        log_wr = 1'b1;
        log_wdata = {4'h0, st.chan};
      end else if (st.log_idx == `SFDL_REC_FLAG_LO) begin
        log_wr = (st.log_ctl != `SFDL_LOG_ADC);
        log_wdata = st.flags[7:0];
      end else if (st.log_idx == `SFDL_REC_FLAG_HI) begin
        log_wr = (st.log_ctl != `SFDL_LOG_ADC);
        log_wdata = {4'h0, st.flags[11:8]};
      end else begin
        log_wr = (st.log_ctl != `SFDL_LOG_FLAGS);
        log_wdata = adc_a;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic uv_v;
    logic ov_v;
    logic ew_v;
    logic crit;
    logic [11:0] bit_ch;
    logic [11:0] set_f;
    logic [11:0] clr_f;
    logic log_done;
    uv_v = 1'b0;
    ov_v = 1'b0;
    ew_v = 1'b0;
    crit = 1'b0;
    bit_ch = 12'h001 << st.chan;
    set_f = 12'h000;
    clr_f = 12'h000;
    log_done = 1'b0;
    next_st = st;

    case (st.state)
      SFDL_IDLE: begin
        if (i_conv_done) begin
          next_st.cur = cur8;
          next_st.state = SFDL_GET_EW;
        end
      end
      SFDL_GET_EW: begin
        next_st.thr_ew = thr_a;
        next_st.state = SFDL_GET_OV;
      end
      SFDL_GET_OV: begin
        next_st.thr_ov = thr_a;
        next_st.state = SFDL_EVAL;
      end
      SFDL_EVAL: begin
        uv_v = st.cur < thr_a;
        ov_v = st.cur > st.thr_ov;
        ew_v = EW_ABOVE[st.chan] ? (st.cur > st.thr_ew) : (st.cur < st.thr_ew);
        next_st.state = SFDL_IDLE;
        if (uv_v || ov_v || ew_v) begin
          if (st.cnt + 4'h1 >= dgl_need(st.dgl)) begin
            next_st.cnt = 4'h0;
            next_st.fault_pin = st.fault_pin | bit_ch;
            if ((uv_v && |(st.en_uv & bit_ch)) || (ov_v && |(st.en_ov & bit_ch))) begin
              set_f = bit_ch;
            end
            crit = (uv_v && |(st.en_uv & bit_ch)) || (ov_v && |(st.en_ov & bit_ch)) ||
                   (ew_v && |(st.en_ew & bit_ch));
            if (crit && !st.lock && (st.log_ctl != `SFDL_LOG_OFF)) begin
              next_st.state = SFDL_LOG;
              next_st.log_idx = `SFDL_REC_HEAD;
            end else begin
              next_st.chan = (st.chan == 4'(`SFDL_NUM_CH - 1)) ? 4'h0 : st.chan + 4'h1;
            end
          end else begin
            next_st.cnt = st.cnt + 4'h1;
          end
        end else begin
          next_st.cnt = 4'h0;
          next_st.fault_pin = st.fault_pin & ~bit_ch;
          next_st.chan = (st.chan == 4'(`SFDL_NUM_CH - 1)) ? 4'h0 : st.chan + 4'h1;
        end
      end
      SFDL_LOG: begin
        next_st.log_idx = st.log_idx + 4'h1;
        if (st.log_idx == `SFDL_REC_LAST) begin
          log_done = 1'b1;
          next_st.log_idx = 4'h0;
          next_st.state = SFDL_IDLE;
          next_st.chan = (st.chan == 4'(`SFDL_NUM_CH - 1)) ? 4'h0 : st.chan + 4'h1;
        end
      end
      default: next_st.state = SFDL_IDLE;
    endcase

    if (crit) begin
      next_st.shutdown = 1'b1;
    end

    // register writes
    if (i_reg_wr && i_reg_ext && !i_reg_nv) begin
      if (i_reg_addr == `SFDL_FLAGS_LO) begin
        clr_f[7:0] = i_reg_wdata;
      end
      if (i_reg_addr == `SFDL_FLAGS_HI) begin
        clr_f[11:8] = i_reg_wdata[3:0];
      end
    end
    next_st.flags = (st.flags & ~clr_f) | set_f;
    if (main_wr(`SFDL_LOG_CTL)) begin
      next_st.log_ctl = i_reg_wdata[1:0];
    end
    if (main_wr(`SFDL_UV_EN_LO)) begin
      next_st.en_uv[7:0] = i_reg_wdata;
    end
    if (main_wr(`SFDL_UV_EN_HI)) begin
      next_st.en_uv[11:8] = i_reg_wdata[3:0];
      next_st.en_ov[3:0] = i_reg_wdata[7:4];
    end
    if (main_wr(`SFDL_OV_EN_LO)) begin
      next_st.en_ov[11:4] = i_reg_wdata;
    end
    if (main_wr(`SFDL_EW_EN_LO)) begin
      next_st.en_ew[7:0] = i_reg_wdata;
    end
    if (main_wr(`SFDL_EW_EN_HI)) begin
      next_st.en_ew[11:8] = i_reg_wdata[3:0];
    end
    if (main_wr(`SFDL_DGL_CFG)) begin
      next_st.dgl = i_reg_wdata[`SFDL_DGL_MSB:`SFDL_DGL_LSB];
    end
    // lock set wins over unlock in the same cycle
    if (main_wr(`SFDL_UNLOCK) && i_reg_wdata[`SFDL_UNLOCK_BIT]) begin
      next_st.lock = 1'b0;
    end
    if (log_done) begin
      next_st.lock = 1'b1;
    end

    next_st.supply_en = next_st.shutdown ? 12'h000 : i_supply_req;

    // reads: data sampled one cycle after the strobe, answered the next
    next_st.rd_q = i_reg_rd;
    next_st.rvalid = st.rd_q;
    if (i_reg_rd) begin
      next_st.rd_addr = i_reg_addr;
      next_st.rd_ext = i_reg_ext;
      next_st.rd_nv = i_reg_nv;
    end
    if (st.rd_q) begin
      next_st.rdata = 8'h00;
      if (st.rd_nv) begin
        next_st.rdata = (st.rd_addr <= 8'(`SFDL_REC_LAST)) ? log_b : 8'h00;
      end else if (st.rd_ext) begin
        if (st.rd_addr == `SFDL_FLAGS_LO) begin
          next_st.rdata = st.flags[7:0];
        end else if (st.rd_addr == `SFDL_FLAGS_HI) begin
          next_st.rdata = {4'h0, st.flags[11:8]};
        end
      end else begin
        case (st.rd_addr)
          `SFDL_LOG_CTL: next_st.rdata = {6'h00, st.log_ctl};
          `SFDL_UV_EN_LO: next_st.rdata = st.en_uv[7:0];
          `SFDL_UV_EN_HI: next_st.rdata = {st.en_ov[3:0], st.en_uv[11:8]};
          `SFDL_OV_EN_LO: next_st.rdata = st.en_ov[11:4];
          `SFDL_EW_EN_LO: next_st.rdata = st.en_ew[7:0];
          `SFDL_EW_EN_HI: next_st.rdata = {4'h0, st.en_ew[11:8]};
          `SFDL_DGL_CFG: next_st.rdata = {st.dgl, 6'h00};
          `SFDL_UNLOCK: next_st.rdata = {6'h00, st.lock, 1'b0};
          default: begin
            if ((st.rd_addr >= `SFDL_THR_FIRST) && (st.rd_addr <= `SFDL_THR_LAST)) begin
              next_st.rdata = thr_b;
            end
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      st <= '0;
      st.state <= SFDL_IDLE;
      st.log_ctl <= `SFDL_RST_LOG_CTL;
      st.dgl <= `SFDL_RST_DGL;
      st.en_uv <= `SFDL_RST_EN;
      st.en_ov <= `SFDL_RST_EN;
      st.en_ew <= `SFDL_RST_EN;
    end else begin
      st <= next_st;
    end
  end

  assign o_chan_sel = st.chan;
  assign o_reg_rdata = st.rdata;
  assign o_reg_rvalid = st.rvalid;
  assign o_supply_en = st.supply_en;
  assign o_fault = st.fault_pin;
  assign o_shutdown = st.shutdown;
  assign o_log_locked = st.lock;
endmodule

/* File: verif/sfdl_monitor.sv */
/* Port checker for sfdl_top, bound at the foot of this file.
   Assumes one clock, synchronous active-low reset, the register map of sfdl_params.svh. */
`timescale 1ns/1ps
`include "sfdl_params.svh"
module sfdl_monitor #(
  parameter int ADC_W = 10
) (
  input wire logic i_clk, // clock
  input wire logic i_reset_n, // sync reset
  input wire logic i_conv_done, // conversion done
  input wire logic [ADC_W-1:0] i_conv_data, // result
  input wire logic [3:0] o_chan_sel, // channel
  input wire logic i_reg_wr, // write strobe
  input wire logic i_reg_rd, // read strobe
  input wire logic [7:0] i_reg_addr, // offset
  input wire logic [7:0] i_reg_wdata, // write data
  input wire logic i_reg_ext, // ext page
  input wire logic i_reg_nv, // log page
  input wire logic [7:0] o_reg_rdata, // read data
  input wire logic o_reg_rvalid, // read valid
  input wire logic [11:0] i_supply_req, // wanted enables
  input wire logic [11:0] o_supply_en, // enables
  input wire logic [11:0] o_fault, // fault pins
  input wire logic o_shutdown, // shutdown
  input wire logic o_log_locked // lock
);
  import sfdl_pkg::*;
  logic unlk;
  assign unlk = i_reg_wr && !i_reg_ext && !i_reg_nv && i_reg_addr == `SFDL_UNLOCK
    && i_reg_wdata[`SFDL_UNLOCK_BIT];
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  ////////////////////////////////////////////////////////////////////////////
  property p_supply_off; o_shutdown |=> o_supply_en == 12'h000; endproperty
  a_supply_off: assert property (p_supply_off) else $error("supply on in shutdown");
  property p_supply_follow;
    !o_shutdown ##1 !o_shutdown |-> o_supply_en == $past(i_supply_req);
  endproperty
  a_supply_follow: assert property (p_supply_follow) else $error("supply lost");
  property p_sd_sticky; o_shutdown |=> o_shutdown; endproperty
  a_sd_sticky: assert property (p_sd_sticky) else $error("shutdown dropped");
  property p_rd_answer; i_reg_rd |-> ##2 o_reg_rvalid; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read unanswered");
  property p_rv_cause; o_reg_rvalid |-> $past(i_reg_rd, 2); endproperty
  a_rv_cause: assert property (p_rv_cause) else $error("stray read valid");
  // a record write ends with the lock rising and the channel moving on
  property p_chan_eval;
    $changed(o_chan_sel) && !$rose(o_log_locked) |-> $past(i_conv_done, 4);
  endproperty
  a_chan_eval: assert property (p_chan_eval) else $error("channel moved early");
  property p_fault_eval; $changed(o_fault) |-> $past(i_conv_done, 4); endproperty
  a_fault_eval: assert property (p_fault_eval) else $error("fault off conversion");
  property p_sd_cause; $rose(o_shutdown) |-> $past(i_conv_done, 4) && o_fault != 12'h000;
  endproperty
  a_sd_cause: assert property (p_sd_cause) else $error("shutdown no fault");
  property p_lock_cause; $rose(o_log_locked) |-> o_shutdown && $past(o_shutdown, 8); endproperty
  a_lock_cause: assert property (p_lock_cause) else $error("lock no log");
  property p_lock_hold; o_log_locked && !unlk |=> o_log_locked; endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lock lost");
  property p_unlock; o_log_locked && unlk |=> !o_log_locked; endproperty
  a_unlock: assert property (p_unlock) else $error("unlock ignored");
  c_shutdown: cover property ($rose(o_shutdown));
  c_unlock: cover property (o_log_locked && unlk);
  c_read: cover property (o_reg_rvalid && i_reg_ext);
endmodule
bind sfdl_top sfdl_monitor #(.ADC_W(ADC_W)) u_mon (.i_clk(i_clk), .i_reset_n(i_reset_n),
  .i_conv_done(i_conv_done), .i_conv_data(i_conv_data), .o_chan_sel(o_chan_sel),
  .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .i_reg_ext(i_reg_ext), .i_reg_nv(i_reg_nv),
  .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .i_supply_req(i_supply_req),
  .o_supply_en(o_supply_en), .o_fault(o_fault), .o_shutdown(o_shutdown),
  .o_log_locked(o_log_locked));

/* File: verif/sfdl_adc_model.sv */
/* Converter model: a conversion every i_gap cycles on the selected channel.
   Assumes the bench sets lvl[] hierarchically and keeps i_gap at 4 or more. */
`timescale 1ns/1ps
module sfdl_adc_model #(
  parameter int ADC_W = 10
) (
  input wire logic i_clk, // clock
  input wire logic i_reset_n, // sync reset
  input wire logic [3:0] i_chan_sel, // channel asked for
  input wire logic [3:0] i_gap, // cycles between conversions
  output logic o_conv_done, // done pulse
  output logic [ADC_W-1:0] o_conv_data // result
);
  logic [7:0] lvl [12];
  int cnt;
  initial begin
    for (int i = 0; i < 12; i++) lvl[i] = 8'h80;
    cnt = 0;
    o_conv_done = 1'b0;
    o_conv_data = '0;
  end
  // low bits all ones so only the top eight bits may decide a compare
  always @(posedge i_clk) begin
    #1;
    cnt = (!i_reset_n || cnt + 1 >= int'(i_gap)) ? 0 : cnt + 1;
    o_conv_done = i_reset_n && cnt == 0;
    o_conv_data = o_conv_done ? {lvl[i_chan_sel], {(ADC_W-8){1'b1}}} : ~o_conv_data;
  end
endmodule

/* File: verif/tb_top.sv */
/* Self-checking bench for sfdl_top with the converter model.
   Assumes the register map of sfdl_params.svh; reads answer two cycles after strobe. */
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch %s expected %h seen %h", n, e, g); end end
module tb_top;
  logic clk, reset_n, conv_done, reg_wr, reg_rd, reg_ext, reg_nv, reg_rvalid;
  logic shutdown, log_locked;
  logic [9:0] conv_data;
  logic [3:0] chan_sel, gap;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [11:0] supply_req, supply_en, fault;
  int mismatches, samples_checked, k, n;
  sfdl_top #(.ADC_W(10)) uut (.i_clk(clk), .i_reset_n(reset_n), .i_conv_done(conv_done),
    .i_conv_data(conv_data), .o_chan_sel(chan_sel), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
    .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_reg_ext(reg_ext), .i_reg_nv(reg_nv),
    .o_reg_rdata(reg_rdata), .o_reg_rvalid(reg_rvalid), .i_supply_req(supply_req),
    .o_supply_en(supply_en), .o_fault(fault), .o_shutdown(shutdown),
    .o_log_locked(log_locked));
  sfdl_adc_model #(.ADC_W(10)) adc (.i_clk(clk), .i_reset_n(reset_n), .i_chan_sel(chan_sel),
    .i_gap(gap), .o_conv_done(conv_done), .o_conv_data(conv_data));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [1:0] pg, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk); #1;
    {reg_nv, reg_ext} = pg;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk); #1;
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [1:0] pg, input logic [7:0] a, input logic [7:0] e,
    input string nm);
    @(posedge clk); #1;
    {reg_nv, reg_ext} = pg;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk); #1;
    reg_rd = 1'b0;
    @(posedge clk);
    #1;
    `CHK("rvalid", 1'b1, reg_rvalid)
    `CHK(nm, e, reg_rdata)
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task final_report;
    if (mismatches == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task t_regs;
    logic [7:0] a [7] = '{8'h48, 8'h49, 8'h4A, 8'h4B, 8'h4C, 8'h4F, 8'h47};
    logic [7:0] e [7] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'hC0, 8'h03};
    rd(2'b01, 8'h18, 8'h00, "flags_lo");
    `CHK("supply_en", 12'hABC, supply_en)
    // thresholds first, so no enable ever meets a zero limit
    for (int c = 0; c < 12; c++) begin
      wr(2'b00, 8'h23 + 8'(3 * c), 8'h30);
      wr(2'b00, 8'h24 + 8'(3 * c), 8'hC0);
      wr(2'b00, 8'h25 + 8'(3 * c), 8'h40);
    end
    for (int i = 0; i < 7; i++) begin
      rd(2'b00, a[i], 8'h00, "cfg_reset");
      wr(2'b00, a[i], 8'hFF);
      rd(2'b00, a[i], e[i], "cfg_rw");
      wr(2'b00, a[i], 8'h00);
    end
    wr(2'b00, 8'h50, 8'hFF);
    rd(2'b00, 8'h50, 8'h00, "unmapped");
    wr(2'b10, 8'h00, 8'hFF);
    rd(2'b10, 8'h00, 8'h00, "record_ro");
    adc.lvl[2] = 8'hC0;
    idle(200);
    `CHK("fault_at_thr", 12'h000, fault)
  endtask
  task t_deglitch;
    gap = 4'd9;
    wr(2'b00, 8'h4F, 8'h80);
    for (k = 0; k < 500 && chan_sel != 4'd2; k++) @(negedge clk);
    adc.lvl[2] = 8'hD0;
    n = 0;
    for (k = 0; k < 500 && !fault[2]; k++) begin
      @(negedge clk);
      if (conv_done) n++;
      if (!fault[2]) `CHK("held_chan", 4'd2, chan_sel)
    end
    `CHK("dgl_count", 4, n)
    `CHK("fault_pin", 12'h004, fault)
    rd(2'b01, 8'h18, 8'h00, "flags_masked");
    adc.lvl[2] = 8'h80;
    for (k = 0; k < 500 && chan_sel != 4'd5; k++) @(negedge clk);
    adc.lvl[5] = 8'h10;
    for (k = 0; k < 2; k++) @(posedge conv_done);
    adc.lvl[5] = 8'h80;
    idle(400);
    `CHK("glitch_dropped", 12'h000, fault)
    wr(2'b00, 8'h4F, 8'h00);
    gap = 4'd5;
  endtask
  task t_critical;
    wr(2'b00, 8'h4A, 8'h01);
    adc.lvl[4] = 8'hD0;
    for (k = 0; k < 500 && !shutdown; k++) idle(1);
    `CHK("shutdown", 1'b1, shutdown)
    idle(1);
    `CHK("supply_off", 12'h000, supply_en)
    for (k = 0; k < 100 && !log_locked; k++) idle(1);
    `CHK("locked", 1'b1, log_locked)
    rd(2'b01, 8'h18, 8'h10, "flags_lo");
    rd(2'b10, 8'h00, 8'h04, "rec_head");
    rd(2'b10, 8'h01, 8'h10, "rec_flag_lo");
    rd(2'b10, 8'h02, 8'h00, "rec_flag_hi");
    rd(2'b10, 8'h07, 8'hD0, "rec_adc4");
    rd(2'b10, 8'h0E, 8'h80, "rec_adc11");
    adc.lvl[4] = 8'h80;
    idle(200);
    wr(2'b01, 8'h18, 8'hEF);
    rd(2'b01, 8'h18, 8'h10, "w0_keeps");
    wr(2'b01, 8'h18, 8'h10);
    rd(2'b01, 8'h18, 8'h00, "w1_clears");
  endtask
  task t_lock_modes;
    wr(2'b00, 8'h48, 8'h80);
    adc.lvl[7] = 8'h10;
    adc.lvl[0] = 8'h70;
    idle(300);
    rd(2'b10, 8'h03, 8'h80, "locked_rec");
    rd(2'b01, 8'h18, 8'h80, "flag_uv7");
    wr(2'b00, 8'h47, 8'h02);
    wr(2'b00, 8'h5D, 8'h02);
    `CHK("unlocked", 1'b0, log_locked)
    for (k = 0; k < 500 && !log_locked; k++) idle(1);
    rd(2'b10, 8'h03, 8'h70, "adc_only_adc");
    rd(2'b10, 8'h01, 8'h10, "adc_only_flag");
    wr(2'b00, 8'h47, 8'h01);
    adc.lvl[0] = 8'h60;
    idle(200);
    wr(2'b00, 8'h5D, 8'h02);
    for (k = 0; k < 500 && !log_locked; k++) idle(1);
    rd(2'b10, 8'h01, 8'h80, "flag_only_flag");
    rd(2'b10, 8'h03, 8'h70, "flag_only_adc");
    wr(2'b00, 8'h47, 8'h03);
    adc.lvl[7] = 8'h08;
    wr(2'b00, 8'h5D, 8'h02);
    idle(400);
    `CHK("off_unlocked", 1'b0, log_locked)
    rd(2'b10, 8'h0A, 8'h10, "off_rec");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {reset_n, reg_wr, reg_rd, reg_ext, reg_nv} = '0;
    {reg_addr, reg_wdata} = '0;
    supply_req = 12'hABC;
    gap = 4'd5;
    mismatches = 0;
    samples_checked = 0;
    idle(8);
    reset_n = 1'b1;
    t_regs();
    t_deglitch();
    t_critical();
    t_lock_modes();
    final_report();
  end
  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    final_report();
  end
endmodule
